// ### rtl/tpio_cfg.svh
/*
 * Offsets, field masks, reset values and timing counts of the three-port GPIO block.
 * Assumes a 32-bit APB with a 12-bit byte address and one register per aligned word.
 */
`ifndef TPIO_CFG_SVH
`define TPIO_CFG_SVH

`define TPIO_ADDR_W        12
// port p registers sit at p*16 plus four times these word offsets
`define TPIO_OFF_DATA      2'h0
`define TPIO_OFF_DIR       2'h1
`define TPIO_OFF_PULL      2'h2
`define TPIO_OFF_WAKE      12'h030
`define TPIO_OFF_STATUS    12'h034
`define TPIO_NUM_PORTS     3

// implemented bits per port, listed c, b, a
`define TPIO_PIN_MASK      {8'hFF, 8'h3F, 8'hFF}
`define TPIO_PULL_MASK     {8'hFF, 8'h3F, 8'h7F}
`define TPIO_DIR_RESET     {8'hFF, 8'h3F, 8'hFF}
`define TPIO_PULL_RESET    {8'hFF, 8'h00, 8'h00}
`define TPIO_DATA_RESET    {8'hFF, 8'h3F, 8'hFF}
`define TPIO_WAKE_RESET    8'h00

`define TPIO_STAT_WAKE_BIT 0
`define TPIO_STAT_PD_BIT   1

// one wait state on every APB access
`define TPIO_WAIT_CYCLES   1

`endif

// ### rtl/tpio_pkg.sv
/*
 * Types shared by the three-port GPIO block.
 * Assumes tpio_cfg.svh supplies the numeric constants.
 */
package tpio_pkg;

  // pad drive of one 8-pin port
  typedef struct packed {
    logic [7:0] drive;
    logic [7:0] oe_n;
    logic [7:0] pull;
  } tpio_pad_type;

  typedef logic [2:0][7:0] tpio_bank_type;

  // source of a warm reset request
  typedef enum logic [1:0] {
    TPIO_RST_NONE     = 2'b00,
    TPIO_RST_DEFAULT  = 2'b01,
    TPIO_RST_WDT_HALT = 2'b10
  } tpio_reset_type;

endpackage : tpio_pkg

// ### rtl/tpio_top.sv
/*
 * Three-port GPIO: data latches, direction, pull-high and port A wake-up, reached over APB.
 * Assumes pad levels arrive asynchronously and that warm reset requests and the power-down
 * level come from logic on pclk.
 */
`timescale 1ns/1ps
`include "tpio_cfg.svh"

module tpio_top (
  // apb
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [`TPIO_ADDR_W-1:0]     paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // system
  input  wire tpio_pkg::tpio_reset_type    warm_reset,
  input  wire logic                        power_down,
  output logic                             wake_pulse,
  // pads
  input  wire logic [7:0]                  pad_a_in,
  input  wire logic [7:0]                  pad_b_in,
  input  wire logic [7:0]                  pad_c_in,
  output tpio_pkg::tpio_pad_type           pad_a,
  output tpio_pkg::tpio_pad_type           pad_b,
  output tpio_pkg::tpio_pad_type           pad_c
);
  import tpio_pkg::*;

  localparam tpio_bank_type PIN_MASK   = `TPIO_PIN_MASK;
  localparam tpio_bank_type PULL_MASK  = `TPIO_PULL_MASK;
  localparam tpio_bank_type DIR_RESET  = `TPIO_DIR_RESET;
  localparam tpio_bank_type PULL_RESET = `TPIO_PULL_RESET;
  localparam tpio_bank_type DATA_RESET = `TPIO_DATA_RESET;

  tpio_bank_type data_latch;
  tpio_bank_type direction;
  tpio_bank_type pullup_enable;
  logic [7:0]    port_a_wake_enable;
  tpio_bank_type pin_meta;
  tpio_bank_type pin_sync;
  logic [7:0]    port_a_prev;
  logic          wake_flag;
  logic          wake_event;
  logic          access;
  logic          wr_take;
  logic          rd_take;
  logic          hit_port;
  logic          hit_wake;
  logic          hit_status;
  logic [1:0]    sel_port;
  logic [1:0]    sel_reg;
  logic          defaults;
  logic [31:0]   next_prdata;
  logic          next_pslverr;
  tpio_bank_type pad_drive;
  tpio_bank_type pad_oe_n;
  tpio_bank_type pad_pull;

  // access phase; a transfer completes on the edge where pready is high
  assign access   = psel & penable;
  assign wr_take  = access & pready & pwrite;
  assign rd_take  = access & ~pready;
  assign sel_port = paddr[5:4];
  assign sel_reg  = paddr[3:2];
  // a watchdog reset during power-down leaves all registers alone
  assign defaults = (warm_reset == TPIO_RST_DEFAULT);

  // address decode
  always_comb begin
    hit_port   = 1'b0;
    hit_wake   = 1'b0;
    hit_status = 1'b0;
    if (paddr[1:0] != 2'h0) begin
      hit_port = 1'b0;
    end else if (paddr == `TPIO_OFF_WAKE) begin
      hit_wake = 1'b1;
    end else if (paddr == `TPIO_OFF_STATUS) begin
      hit_status = 1'b1;
    end else if (paddr[11:6] == 6'h00 && sel_port < 2'h3 && sel_reg < 2'h3) begin
      hit_port = 1'b1;
    end
  end

  // pad synchronisers: two flops before any reader
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= {pad_c_in, pad_b_in, pad_a_in};
      pin_sync <= pin_meta;
    end
  end

  // register file; a write stores pwdata[7:0] under the pin or pull mask
  genvar p;
  generate
    for (p = 0; p < `TPIO_NUM_PORTS; p++) begin : g_port
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          data_latch[p]    <= DATA_RESET[p];
          direction[p]     <= DIR_RESET[p];
          pullup_enable[p] <= PULL_RESET[p];
        end else if (defaults) begin
          data_latch[p]    <= DATA_RESET[p];
          direction[p]     <= DIR_RESET[p];
          pullup_enable[p] <= PULL_RESET[p];
        end else if (wr_take && hit_port && sel_port == 2'(p)) begin
          if (sel_reg == `TPIO_OFF_DATA) begin
            data_latch[p] <= pwdata[7:0] & PIN_MASK[p];
          end else if (sel_reg == `TPIO_OFF_DIR) begin
            direction[p] <= pwdata[7:0] & PIN_MASK[p];
          end else if (sel_reg == `TPIO_OFF_PULL) begin
            pullup_enable[p] <= pwdata[7:0] & PULL_MASK[p];
          end
        end
      end

      // pad drive, all registered
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pad_drive[p] <= DATA_RESET[p];
          pad_oe_n[p]  <= DIR_RESET[p] | ~PIN_MASK[p];
          pad_pull[p]  <= DIR_RESET[p] & PULL_RESET[p];
        end else begin
          pad_drive[p] <= data_latch[p];
          pad_oe_n[p]  <= direction[p] | ~PIN_MASK[p];
          pad_pull[p]  <= direction[p] & pullup_enable[p];
        end
      end
    end
  endgenerate

  assign pad_a = '{drive: pad_drive[0], oe_n: pad_oe_n[0], pull: pad_pull[0]};
  assign pad_b = '{drive: pad_drive[1], oe_n: pad_oe_n[1], pull: pad_pull[1]};
  assign pad_c = '{drive: pad_drive[2], oe_n: pad_oe_n[2], pull: pad_pull[2]};

  // port a wake enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_a_wake_enable <= `TPIO_WAKE_RESET;
    end else if (defaults) begin
      port_a_wake_enable <= `TPIO_WAKE_RESET;
    end else if (wr_take && hit_wake) begin
      port_a_wake_enable <= pwdata[7:0];
    end
  end

  // falling edge on an enabled port a pin while powered down
  assign wake_event = power_down & |(port_a_prev & ~pin_sync[0] & port_a_wake_enable);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_a_prev <= '0;
      wake_pulse  <= 1'b0;
    end else begin
      port_a_prev <= pin_sync[0];
      wake_pulse  <= wake_event;
    end
  end

  // sticky wake flag, write one to clear; a new event wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_flag <= 1'b0;
    end else if (wake_event) begin
      wake_flag <= 1'b1;
    end else if (wr_take && hit_status && pwdata[`TPIO_STAT_WAKE_BIT]) begin
      wake_flag <= 1'b0;
    end
  end

  // read mux: input pins show the live level, outputs the latch
  always_comb begin
    next_prdata  = '0;
    next_pslverr = 1'b0;
    if (hit_port) begin
      if (sel_reg == `TPIO_OFF_DATA) begin
        next_prdata[7:0] = ((direction[sel_port] & pin_sync[sel_port])
                          | (~direction[sel_port] & data_latch[sel_port]))
                          & PIN_MASK[sel_port];
      end else if (sel_reg == `TPIO_OFF_DIR) begin
        next_prdata[7:0] = direction[sel_port];
      end else begin
        next_prdata[7:0] = pullup_enable[sel_port];
      end
    end else if (hit_wake) begin
      next_prdata[7:0] = port_a_wake_enable;
    end else if (hit_status) begin
      next_prdata[`TPIO_STAT_WAKE_BIT] = wake_flag;
      next_prdata[`TPIO_STAT_PD_BIT]   = power_down;
    end else begin
      next_pslverr = 1'b1;
    end
  end

  // apb answer: one wait state, then pready with data for one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      pready  <= rd_take;
      pslverr <= rd_take & next_pslverr;
      if (rd_take && !pwrite) begin
        prdata <= next_prdata;
      end
    end
  end

endmodule : tpio_top

// ### tb/tpio_asserts.sv
/* Port checker for the GPIO block.
   Assumes it is bound into tpio_top, one pclk domain. */
`timescale 1ns/1ps
module tpio_asserts (
  // clock and reset
  input wire logic                    pclk,
  input wire logic                    presetn,
  // apb
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic                    pready,
  input wire logic                    pslverr,
  // system
  input wire tpio_pkg::tpio_reset_type warm_reset,
  input wire logic                    power_down,
  input wire logic                    wake_pulse,
  // pads
  input wire tpio_pkg::tpio_pad_type  pad_a,
  input wire tpio_pkg::tpio_pad_type  pad_b,
  input wire tpio_pkg::tpio_pad_type  pad_c
);
  import tpio_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  one_wait_a: assert property (psel && penable && !pready |=> pready) else $error("pready late");
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
  err_ready_a: assert property (pslverr |-> pready) else $error("pslverr alone");
  pull_input_a: assert property ((pad_a.pull & ~pad_a.oe_n | pad_b.pull & ~pad_b.oe_n | pad_c.pull & ~pad_c.oe_n) == 0)
    else $error("pull on output");
  top_pull_a: assert property (pad_a.pull[7] == 1'b0) else $error("top pin pulled");
  b_upper_a: assert property (pad_b.pull[7:6] == 2'h0 && pad_b.oe_n[7:6] == 2'h3) else $error("port b upper");
  reset_pads_a: assert property ($rose(presetn) |-> pad_c.pull == 8'hFF && pad_a.oe_n == 8'hFF)
    else $error("reset pads");
  // a write or default reset taken at edge E reaches the pad at edge E+1 and is seen by this check at edge E+2
  latch_hold_a: assert property ($changed(pad_c.drive) |-> $past(pready, 2) && $past(pwrite, 2)
    || $past(warm_reset, 2) == TPIO_RST_DEFAULT) else $error("latch moved");
  halt_hold_a: assert property (warm_reset == TPIO_RST_WDT_HALT && !pready |=> $stable(pad_c))
    else $error("halt reset changed pads");
  wake_pd_a: assert property (wake_pulse |-> $past(power_down)) else $error("wake while running");
  cover property (pslverr);
  cover property (wake_pulse);
  cover property (warm_reset == TPIO_RST_WDT_HALT);
endmodule : tpio_asserts

// ### tb/tpio_pins.sv
/* Switches and loads on one 8-pin port.
   Assumes the pad struct of the block; open pins wander. */
`timescale 1ns/1ps
module tpio_pins (
  // clock
  input wire logic                   pclk,
  // pad side
  input wire tpio_pkg::tpio_pad_type pad,
  output logic [7:0]                 level,
  // switches
  input wire logic [7:0]             sw,
  input wire logic [7:0]             sw_on
);
  import tpio_pkg::*;
  logic [7:0] wander = 8'h55;
  always @(posedge pclk) wander <= ~wander;
  // driven pin wins, then switch, then pull-high, else drifting
  assign level = ~pad.oe_n & pad.drive | pad.oe_n & (sw_on & sw | ~sw_on & (pad.pull | wander));
endmodule : tpio_pins

// ### tb/tpio_top_tb.sv
/* Bench for the three-port GPIO block.
   Assumes tpio_pins on each port and the bound checker. */
`timescale 1ns/1ps
module tpio_top_tb;
  import tpio_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pd = 0, wk, rdy, slv, ef;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prd, r, seed = 32'h4564F101;
  tpio_reset_type warm = TPIO_RST_NONE;
  tpio_bank_type sw = 0, on = 0;
  tpio_pad_type pads [3];
  logic [7:0] lv [3];
  logic [11:0] ra [7] = '{12'h004, 12'h008, 12'h014, 12'h018, 12'h024, 12'h028, 12'h030};
  logic [7:0] rv [7] = '{8'hFF, 8'h00, 8'h3F, 8'h00, 8'hFF, 8'hFF, 8'h00};
  int bad_count = 0, n_checks = 0;
  always #12.5 pclk = ~pclk;
  tpio_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prd), .pready(rdy), .pslverr(slv), .warm_reset(warm), .power_down(pd),
    .wake_pulse(wk), .pad_a_in(lv[0]), .pad_b_in(lv[1]), .pad_c_in(lv[2]), .pad_a(pads[0]),
    .pad_b(pads[1]), .pad_c(pads[2]));
  for (genvar g = 0; g < 3; g++) begin : sw_g
    tpio_pins pins (.pclk(pclk), .pad(pads[g]), .level(lv[g]), .sw(sw[g]), .sw_on(on[g]));
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task summarize;
    if (bad_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", n, e, g);
      bad_count++;
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
    int i;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (rdy !== 1'b1 && i < 20);
    if (rdy !== 1'b1) begin
      bad_count++;
      summarize;
    end
    q = prd;
    e = slv;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask : apb
  initial begin : main
    logic [7:0] dir, pu, dat, pm, mk, kn, ex;
    int p;
    repeat (5) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    foreach (ra[i]) begin
      apb(0, ra[i], 0, r, ef);
      chk("reset value", 32'(rv[i]), r);
    end
    for (int k = 0; k < 9; k++) begin
      p = k % 3;
      seed = xs(seed);
      {dat, pu, dir} = seed[23:0];
      if (k < 3) pu = 8'hFF;
      seed = xs(seed);
      sw[p] <= seed[7:0];
      on[p] <= seed[15:8];
      mk = (p == 1) ? 8'h3F : 8'hFF;
      pm = (p == 0) ? 8'h7F : mk;
      apb(1, 12'(p * 16 + 4), 32'(dir), r, ef);
      apb(1, 12'(p * 16 + 8), 32'(pu), r, ef);
      apb(1, 12'(p * 16), 32'(dat), r, ef);
      apb(0, 12'(p * 16 + 8), 0, r, ef);
      chk("pullup", 32'(pu & pm), r);
      apb(0, 12'(p * 16), 0, r, ef);
      dir = dir & mk;
      pu = pu & pm;
      kn = ~dir | on[p] | pu;
      ex = dir & (on[p] & sw[p] | ~on[p] & pu) | ~dir & dat & mk;
      chk("port read", 32'(ex & kn), r & 32'(kn));
      chk("pads", 32'({dat & mk, dir | ~mk, dir & pu}), 32'(pads[p]));
    end
    apb(0, 12'h03C, 0, r, ef);
    chk("unmapped err", 32'(ef), 1);
    chk("unmapped data", 0, r);
    apb(1, 12'h025, 32'hFF, r, ef);
    chk("misaligned err", 32'(ef), 1);
    apb(1, 12'h024, 32'h5A, r, ef);
    warm <= TPIO_RST_WDT_HALT;
    @(posedge pclk);
    warm <= TPIO_RST_NONE;
    apb(0, 12'h024, 0, r, ef);
    chk("halt kept", 32'h5A, r);
    warm <= TPIO_RST_DEFAULT;
    @(posedge pclk);
    warm <= TPIO_RST_NONE;
    apb(0, 12'h024, 0, r, ef);
    chk("default", 32'hFF, r);
    apb(1, 12'h004, 32'hFF, r, ef);
    apb(1, 12'h030, 32'h1, r, ef);
    sw[0] <= 8'hFF;
    on[0] <= 8'hFF;
    pd <= 1;
    repeat (4) @(posedge pclk);
    sw[0] <= 8'hFE;
    ef = 0;
    repeat (6) begin
      @(posedge pclk);
      if (wk === 1'b1) ef = 1;
    end
    chk("wake", 32'(ef), 1);
    apb(0, 12'h034, 0, r, ef);
    chk("wake status", 32'h3, r);
    apb(1, 12'h034, 32'h1, r, ef);
    apb(0, 12'h034, 0, r, ef);
    chk("wake cleared", 32'h2, r);
    // falling edge on a pin whose wake enable is clear
    sw[0] <= 8'hFC;
    ef = 0;
    repeat (6) begin
      @(posedge pclk);
      if (wk !== 1'b0) ef = 1;
    end
    chk("masked wake", 32'(ef), 0);
    summarize;
  end
endmodule : tpio_top_tb
bind tpio_top tpio_asserts chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .warm_reset(warm_reset), .power_down(power_down),
  .wake_pulse(wake_pulse), .pad_a(pad_a), .pad_b(pad_b), .pad_c(pad_c));
